// ### pkg/rbc_consts.svh
/*
 Constants for the RF bias control output block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH
`define RBC_CTRL_REG_IDX   8'h07
`define RBC_PORT_MODE_BIT  12
`define RBC_INVERT_BIT     13
`define RBC_ENABLE_BIT     14
`define RBC_CTRL_RESET     16'h0000
`define RBC_ENABLE_RESET   1'b0
`define RBC_INVERT_RESET   1'b0
`define RBC_MODE_RESET     1'b0
`endif

// ### pkg/rbc_pkg.sv
/*
 Types for the RF bias control output block.
 Assumes the modem supplies its state in the encoding below.
*/
package rbc_pkg;
   typedef enum logic [2:0] {
      RBC_ST_OFF  = 3'b000,
      RBC_ST_IDLE = 3'b001,
      RBC_ST_DOZE = 3'b010,
      RBC_ST_HIB  = 3'b011,
      RBC_ST_RX   = 3'b100,
      RBC_ST_TX   = 3'b101
   } rbc_modem_state_t;
endpackage : rbc_pkg

// ### hdl/rbc_level_sel.sv
/*
 Combinational choice of the bias pin level and drive.
 Assumes control bits and modem state are stable in the modem clock domain.
*/
`timescale 1ns/1ns
`include "rbc_consts.svh"
module rbc_level_sel
   import rbc_pkg::*;
(
   input  wire logic             bias_out_enable_i,
   input  wire logic             bias_polarity_invert_i,
   input  wire logic             port_mode_select_i,
   input  wire rbc_modem_state_t state_i,
   output wire logic             level_o,
   output wire logic             drive_o
);
   wire logic is_tx;
   wire logic is_active;
   wire logic dual_inv;

   assign is_tx     = (state_i == RBC_ST_TX);
   assign is_active = (state_i == RBC_ST_TX) || (state_i == RBC_ST_RX);
   // Invert only acts in dual-port mode
   assign dual_inv  = bias_polarity_invert_i & ~port_mode_select_i;
   // Quiet states force low; active states follow TX with optional swap
   assign level_o   = is_active ? (is_tx ^ dual_inv) : 1'b0;
   // Off still drives when enabled; its level is of no concern
   assign drive_o   = bias_out_enable_i;
endmodule : rbc_level_sel

// ### hdl/rbc_bias_ctrl.sv
/*
 RF bias control output: drives the bias pin for a balun centre tap,
 LNA, PA or antenna switch from three control bits and the modem state.
 Assumes control bits come from the modem's control register logic and all
 inputs except arst_n_i, which is synchronized here, are synchronous to clk_i.
*/
`timescale 1ns/1ns
`include "rbc_consts.svh"
module rbc_bias_ctrl
   import rbc_pkg::*;
(
   input  wire logic             clk_i,
   input  wire logic             arst_n_i,
   input  wire logic             ctrl_wr_i,
   input  wire logic [15:0]      ctrl_wdata_i,
   input  wire rbc_modem_state_t state_i,
   output logic                  bias_ctrl_out_o,
   output logic                  bias_ctrl_out_oe_o,
   output logic                  bias_out_enable_o,
   output logic                  bias_polarity_invert_o,
   output logic                  port_mode_select_o
);
   logic rst_meta;
   logic rst_n;
   wire logic next_level;
   wire logic next_drive;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Control bits of the modem control register
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bias_out_enable_o      <= `RBC_ENABLE_RESET;
         bias_polarity_invert_o <= `RBC_INVERT_RESET;
         port_mode_select_o     <= `RBC_MODE_RESET;
      end else if (ctrl_wr_i) begin
         bias_out_enable_o      <= ctrl_wdata_i[`RBC_ENABLE_BIT];
         bias_polarity_invert_o <= ctrl_wdata_i[`RBC_INVERT_BIT];
         port_mode_select_o     <= ctrl_wdata_i[`RBC_PORT_MODE_BIT];
      end
   end

   rbc_level_sel u_sel (
      .bias_out_enable_i      (bias_out_enable_o),
      .bias_polarity_invert_i (bias_polarity_invert_o),
      .port_mode_select_i     (port_mode_select_o),
      .state_i                (state_i),
      .level_o                (next_level),
      .drive_o                (next_drive)
   );

   // Registered pin keeps glitches off the external switch control
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bias_ctrl_out_o    <= 1'b0;
         bias_ctrl_out_oe_o <= 1'b0;
      end else begin
         bias_ctrl_out_o    <= next_level & next_drive;
         bias_ctrl_out_oe_o <= next_drive;
      end
   end

   property p_tristate;
      @(posedge clk_i) disable iff (!rst_n)
         !bias_out_enable_o |=> !bias_ctrl_out_oe_o;
   endproperty
   a_tristate: assert property (p_tristate) else $error("Pin driven while disabled");

   property p_single;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && port_mode_select_o && (state_i inside {RBC_ST_TX, RBC_ST_RX})
         |=> bias_ctrl_out_oe_o && (bias_ctrl_out_o == ($past(state_i) == RBC_ST_TX));
   endproperty
   a_single: assert property (p_single) else $error("Single-port level wrong");

   property p_dual;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && !port_mode_select_o && (state_i inside {RBC_ST_TX, RBC_ST_RX})
         |=> bias_ctrl_out_o ==
             (($past(state_i) == RBC_ST_TX) ^ $past(bias_polarity_invert_o));
   endproperty
   a_dual: assert property (p_dual) else $error("Dual-port level wrong");

   property p_quiet;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && (state_i inside {RBC_ST_IDLE, RBC_ST_DOZE, RBC_ST_HIB})
         |=> bias_ctrl_out_oe_o && !bias_ctrl_out_o;
   endproperty
   a_quiet: assert property (p_quiet) else $error("Quiet state not low");

   property p_switch;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && $stable(bias_out_enable_o) && $stable(port_mode_select_o)
         && $stable(bias_polarity_invert_o) && (state_i == RBC_ST_RX)
         && ($past(state_i) == RBC_ST_TX) |=> $changed(bias_ctrl_out_o);
   endproperty
   a_switch: assert property (p_switch) else $error("No switch on TX/RX change");

   property p_reset_bits;
      @(posedge clk_i) $rose(rst_n) |-> !bias_out_enable_o && !port_mode_select_o
         && !bias_polarity_invert_o && !bias_ctrl_out_oe_o;
   endproperty
   a_reset_bits: assert property (p_reset_bits) else $error("Bad reset values");

   // Reference level written row by row from the output table; it is kept
   // apart from the selector so the checks do not share its expression
   function automatic logic table_level(input logic             single_port,
                                        input logic             invert,
                                        input rbc_modem_state_t st);
      logic lvl;
      lvl = 1'b0;
      unique case (st)
         RBC_ST_TX: begin
            lvl = single_port ? 1'b1 : ~invert;
         end
         RBC_ST_RX: begin
            lvl = single_port ? 1'b0 : invert;
         end
         RBC_ST_OFF, RBC_ST_IDLE, RBC_ST_DOZE, RBC_ST_HIB: begin
            lvl = 1'b0;
         end
         // Codes 110 and 111 are never sent by the modem
         default: begin
            lvl = 1'b0;
         end
      endcase
      return lvl;
   endfunction : table_level

   wire logic ref_level;
   assign ref_level = table_level(port_mode_select_o, bias_polarity_invert_o, state_i);

   property p_table;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && (state_i != RBC_ST_OFF)
         |=> bias_ctrl_out_o == $past(ref_level);
   endproperty
   a_table: assert property (p_table) else $error("Pin differs from table");

   // Each control bit lands on the edge that takes the write
   property p_enable_load;
      @(posedge clk_i) disable iff (!rst_n)
         ctrl_wr_i |=> bias_out_enable_o == $past(ctrl_wdata_i[`RBC_ENABLE_BIT]);
   endproperty
   a_enable_load: assert property (p_enable_load) else $error("Enable bit not loaded");

   property p_invert_load;
      @(posedge clk_i) disable iff (!rst_n)
         ctrl_wr_i |=> bias_polarity_invert_o == $past(ctrl_wdata_i[`RBC_INVERT_BIT]);
   endproperty
   a_invert_load: assert property (p_invert_load) else $error("Invert bit not loaded");

   property p_mode_load;
      @(posedge clk_i) disable iff (!rst_n)
         ctrl_wr_i |=> port_mode_select_o == $past(ctrl_wdata_i[`RBC_PORT_MODE_BIT]);
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("Mode bit not loaded");

   property p_ctrl_hold;
      @(posedge clk_i) disable iff (!rst_n)
         !ctrl_wr_i |=> $stable(bias_out_enable_o) && $stable(bias_polarity_invert_o)
         && $stable(port_mode_select_o);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("Control bit moved");

   property p_released_low;
      @(posedge clk_i) disable iff (!rst_n)
         !bias_ctrl_out_oe_o |-> !bias_ctrl_out_o;
   endproperty
   a_released_low: assert property (p_released_low) else $error("Released pin not low");

   property p_enable_drives;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o |=> bias_ctrl_out_oe_o;
   endproperty
   a_enable_drives: assert property (p_enable_drives) else $error("Pin not driven");

   property p_switch_up;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && $stable(bias_out_enable_o) && $stable(port_mode_select_o)
         && $stable(bias_polarity_invert_o) && (state_i == RBC_ST_TX)
         && ($past(state_i) == RBC_ST_RX) |=> $changed(bias_ctrl_out_o);
   endproperty
   a_switch_up: assert property (p_switch_up) else $error("No switch on RX to TX");

   // A move with no cause would flip an external switch for nothing
   property p_pin_holds;
      @(posedge clk_i) disable iff (!rst_n)
         $stable(state_i) && $stable(bias_out_enable_o) && $stable(port_mode_select_o)
         && $stable(bias_polarity_invert_o)
         |=> $stable(bias_ctrl_out_o) && $stable(bias_ctrl_out_oe_o);
   endproperty
   a_pin_holds: assert property (p_pin_holds) else $error("Pin moved with no cause");

   property p_single_keep;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && port_mode_select_o && $stable(bias_out_enable_o)
         && $stable(port_mode_select_o) && $stable(state_i)
         && $changed(bias_polarity_invert_o) |=> $stable(bias_ctrl_out_o);
   endproperty
   a_single_keep: assert property (p_single_keep) else $error("Single-port pin moved");

   property p_dual_swap;
      @(posedge clk_i) disable iff (!rst_n)
         bias_out_enable_o && !port_mode_select_o && $stable(bias_out_enable_o)
         && $stable(port_mode_select_o) && $stable(state_i)
         && (state_i inside {RBC_ST_TX, RBC_ST_RX})
         && $changed(bias_polarity_invert_o) |=> $changed(bias_ctrl_out_o);
   endproperty
   a_dual_swap: assert property (p_dual_swap) else $error("Invert did not swap pin");

   // Internal reset must stay low for two edges after the pin lets go
   property p_sync_release;
      @(posedge clk_i) disable iff (!arst_n_i)
         $rose(arst_n_i) |-> !rst_n ##1 !rst_n ##1 rst_n;
   endproperty
   a_sync_release: assert property (p_sync_release) else $error("Early reset release");

   property p_reset_pin;
      @(posedge clk_i) $rose(rst_n) |-> !bias_ctrl_out_o;
   endproperty
   a_reset_pin: assert property (p_reset_pin) else $error("Pin level after reset");
endmodule : rbc_bias_ctrl

// ### sim/rbc_load_model.sv
/*
 Load on the bias pin: balun tap, LNA, PA or antenna switch input.
 Assumes the block drives the pin value only while its enable is high.
*/
`timescale 1ns/1ns
module rbc_load_model (
   input  wire logic drv_i,
   input  wire logic oe_i,
   output wire logic pin_o
);
   // No pull on the net, so a released pin stays floating
   assign pin_o = oe_i ? drv_i : 1'bz;
endmodule : rbc_load_model

// ### sim/rbc_bias_ctrl_test.sv
/*
 Self-checking bench for the bias control block.
 Assumes one 125 MHz clock and the load model on the pin.
*/
`timescale 1ns/1ns
module rbc_bias_ctrl_test
   import rbc_pkg::*;
;
   logic             clk = 1'b0;
   logic             arst_n = 1'b0;
   logic             wr = 1'b0;
   logic [15:0]      wd = 16'h0000;
   rbc_modem_state_t st = RBC_ST_IDLE;
   wire logic        out, oe, en, inv, mode, pin;
   int               num_errors = 0;
   int               samples_checked = 0;
   always #4 clk = ~clk;
   rbc_bias_ctrl u_rbc_bias_ctrl (.clk_i(clk), .arst_n_i(arst_n), .ctrl_wr_i(wr),
      .ctrl_wdata_i(wd), .state_i(st), .bias_ctrl_out_o(out), .bias_ctrl_out_oe_o(oe),
      .bias_out_enable_o(en), .bias_polarity_invert_o(inv), .port_mode_select_o(mode));
   rbc_load_model u_rbc_load_model (.drv_i(out), .oe_i(oe), .pin_o(pin));
   task cyc;
      @(posedge clk);
      #1;
   endtask : cyc
   task chk(input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t exp %h got %h", $time, e, g);
      end
   endtask : chk
   function logic exp_pin(input logic e, m, i, input rbc_modem_state_t s);
      if (!e) return 1'bz;
      if (s == RBC_ST_RX) return m ? 1'b0 : i;
      if (s == RBC_ST_TX) return m ? 1'b1 : !i;
      return 1'b0;
   endfunction : exp_pin
   // Unused bits set to show the word's other bits are ignored
   task put(input logic e, m, i);
      wd = {1'b1, e, i, m, 12'hFFF};
      wr = 1'b1;
      cyc;
      wr = 1'b0;
      chk(e, en);
      chk(i, inv);
      chk(m, mode);
      cyc;
   endtask : put
   task t_reset;
      chk(1'b0, en);
      chk(1'b0, inv);
      chk(1'b0, mode);
      chk(1'bz, pin);
   endtask : t_reset
   task t_table;
      for (int k = 0; k < 8; k++) begin
         put(k[2], k[1], k[0]);
         for (int s = 1; s < 6; s++) begin
            st = rbc_modem_state_t'(s);
            cyc;
            chk(exp_pin(k[2], k[1], k[0], st), pin);
         end
      end
   endtask : t_table
   task t_toggle;
      put(1'b1, 1'b0, 1'b1);
      for (int n = 0; n < 6; n++) begin
         st = n[0] ? RBC_ST_TX : RBC_ST_RX;
         cyc;
         chk(n[0] ? 1'b0 : 1'b1, pin);
      end
   endtask : t_toggle
   // Reset in mid-run while driving must release the pin at once
   task t_restart;
      arst_n = 1'b0;
      cyc;
      chk(1'b0, en);
      chk(1'b0, inv);
      chk(1'b0, mode);
      chk(1'bz, pin);
      arst_n = 1'b1;
      repeat (3) cyc;
      put(1'b1, 1'b1, 1'b0);
      st = RBC_ST_TX;
      cyc;
      chk(1'b1, pin);
   endtask : t_restart
   task wrap_up;
      $display("Checked %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (2) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (3) cyc;
      t_reset;
      t_table;
      t_toggle;
      t_restart;
      wrap_up;
   end
   // Run needs well under a thousand cycles
   initial begin
      #20000;
      num_errors++;
      wrap_up;
   end
endmodule : rbc_bias_ctrl_test
